// *** tcap_link_if.sv ***
// Three-wire link between serial master and tunable capacitor
`timescale 1ns/1ps
`default_nettype none
interface tcap_link_if;
   logic serial_latch_enable;
   logic serial_clock;
   logic serial_data;
   modport master (output serial_latch_enable, output serial_clock, output serial_data);
   modport device (input serial_latch_enable, input serial_clock, input serial_data);
endinterface
`default_nettype wire

// *** tcap_link_properties.sv ***
// Link timing and content checks
`timescale 1ns/1ps
`default_nettype none
module tcap_link_properties (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Link and applied state
   input wire logic       serial_latch_enable,
   input wire logic       serial_clock,
   input wire logic       serial_data,
   input wire logic       standby_select,
   input wire logic [4:0] capacitance_state_code,
   input wire logic       word_applied
);
   logic [7:0] sh_ff;
   logic [3:0] cnt_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Mirror of the shift path, sampled on the system clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sh_ff <= 8'h00;
         cnt_ff <= 4'h0;
      end else if ($rose(serial_latch_enable)) begin
         cnt_ff <= 4'h0;
      end else if ($rose(serial_clock)) begin
         sh_ff <= {sh_ff[6:0], serial_data};
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   frame_clock_a: assert property (serial_clock |-> serial_latch_enable)
      else $error("clock high outside frame");
   data_stable_a: assert property (serial_clock |-> $stable(serial_data))
      else $error("data moved while clock high");
   bit_count_a: assert property ($fell(serial_latch_enable) |-> cnt_ff == 4'h8)
      else $error("frame without eight clocks");
   reserved_zero_a: assert property ($fell(serial_latch_enable) |-> sh_ff[7:6] == 2'b00)
      else $error("reserved bits not zero");
   apply_delay_a: assert property ($fell(serial_latch_enable) |-> ##[2:6] word_applied)
      else $error("word not applied after enable fall");
   apply_idle_a: assert property (word_applied |-> !serial_latch_enable)
      else $error("word applied inside frame");
   word_match_a: assert property (word_applied |=>
      {standby_select, capacitance_state_code} == sh_ff[5:0])
      else $error("applied state differs from shifted bits");
   state_hold_a: assert property ($changed({standby_select, capacitance_state_code})
      |-> word_applied || $past(word_applied)) else $error("state changed without apply");
   cover property ($fell(serial_latch_enable));
   cover property (word_applied ##1 standby_select);
   cover property (word_applied ##1 capacitance_state_code == 5'h1f);
endmodule // tcap_link_properties
`default_nettype wire

// *** tcap_map.svh ***
// Constants for the tunable capacitor serial control link
`ifndef TCAP_MAP_SVH
`define TCAP_MAP_SVH
`define TCAP_WORD_BITS      8
`define TCAP_RSV_HI         7
`define TCAP_RSV_LO         6
`define TCAP_STBY_BIT       5
`define TCAP_CODE_HI        4
`define TCAP_CODE_LO        0
`define TCAP_CNT_BITS       4
`define TCAP_CLK_DIV        2
`define TCAP_DIV_BITS       4
`define TCAP_DIV_MIN        2
`define TCAP_DIV_MAX        15
`define TCAP_WORD_MASK      8'h3f
`define TCAP_REG_CTRL       4'h0
`define TCAP_REG_STATUS     4'h1
`define TCAP_REG_LAST       4'h2
`define TCAP_CTRL_SEND_BIT  0
`define TCAP_STAT_BUSY_BIT  0
`define TCAP_STAT_DONE_BIT  1
`endif

// *** tcap_pkg.sv ***
// Types for the tunable capacitor link; the word type is shared by both ends, the state type is the master's
package tcap_pkg;
   typedef logic [7:0] tcap_word_t;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_HIGH,
      ST_LOW,
      ST_TAIL,
      ST_GAP
   } master_state_t;
endpackage

// *** tcap_serial_master.sv ***
// Serial master: register port to three-wire telegram
// Behaviour
// - Raise enable before first clock edge
// - Device samples data on rising clock
// - Send most significant bit first
// - Change data only at falling clock
// - Device applies word at enable fall; here latched at the fall, applied three clocks later
// - Device keeps only last eight bits
// - Own enable frames each device's telegram
// - Shared enable needs full telegram everywhere
// - Top two bits always sent zero
// - Standby bit one selects low-current standby
// - Low five bits choose capacitance state
`timescale 1ns/1ps
`default_nettype none
`include "tcap_map.svh"
module tcap_serial_master #(
   parameter int CLK_DIV = `TCAP_CLK_DIV
) (
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  rst,
   // Register port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   // Link
   tcap_link_if.master link
);
   import tcap_pkg::*;

   // Refuse divider settings the phase counter cannot hold
   if (CLK_DIV < `TCAP_DIV_MIN || CLK_DIV > `TCAP_DIV_MAX) begin : g_bad_div
      $error("CLK_DIV out of range");
   end

   // Bit counter must be able to reach a full word
   if (`TCAP_WORD_BITS >= (1 << `TCAP_CNT_BITS)) begin : g_bad_cnt
      $error("bit counter too narrow for the telegram");
   end

   localparam int                        WORD_MSB = `TCAP_WORD_BITS - 1;
   localparam logic [`TCAP_DIV_BITS-1:0] DIV_LAST = `TCAP_DIV_BITS'(CLK_DIV - 1);
   localparam logic [`TCAP_CNT_BITS-1:0] BIT_LAST = `TCAP_CNT_BITS'(`TCAP_WORD_BITS);

   master_state_t             state_ff;
   master_state_t             nxt_state;
   tcap_word_t                word_ff;
   tcap_word_t                nxt_word;
   tcap_word_t                last_ff;
   tcap_word_t                nxt_last;
   tcap_word_t                rdata_ff;
   tcap_word_t                nxt_rdata;
   logic [`TCAP_CNT_BITS-1:0] bit_ff;
   logic [`TCAP_CNT_BITS-1:0] nxt_bit;
   logic [`TCAP_DIV_BITS-1:0] div_ff;
   logic [`TCAP_DIV_BITS-1:0] nxt_div;
   logic                      done_ff;
   logic                      nxt_done;
   logic                      sen_ff;
   logic                      nxt_sen;
   logic                      scl_ff;
   logic                      nxt_scl;
   logic                      sda_ff;
   logic                      nxt_sda;

   // Register decode
   wire idle      = state_ff == ST_IDLE;
   wire busy      = !idle;
   wire wr_ctrl   = wr && addr == `TCAP_REG_CTRL;
   wire wr_word   = wr && addr == `TCAP_REG_LAST;
   wire rd_status = rd && addr == `TCAP_REG_STATUS;
   wire send_req  = wr_ctrl && wdata[`TCAP_CTRL_SEND_BIT];
   // Word writes during a frame are dropped so a telegram cannot tear
   wire load_word = wr_word && idle;

   // Phase timing
   wire tick      = div_ff == DIV_LAST;
   wire fall_edge = state_ff == ST_HIGH && tick;
   wire last_bit  = bit_ff == BIT_LAST;
   wire frame_end = state_ff == ST_TAIL && tick;
   wire in_frame  = nxt_state inside {ST_LEAD, ST_HIGH, ST_LOW, ST_TAIL};

   // Status and read port; reserved top bits forced to zero
   wire [7:0] clean_word = wdata & `TCAP_WORD_MASK;
   wire [7:0] status     = (tcap_word_t'(busy) << `TCAP_STAT_BUSY_BIT) |
                           (tcap_word_t'(done_ff) << `TCAP_STAT_DONE_BIT);
   wire [7:0] rd_mux     = (addr == `TCAP_REG_STATUS) ? status :
                           (addr == `TCAP_REG_LAST)   ? last_ff : '0;

   // Next values
   assign nxt_div   = (idle || tick) ? '0 : div_ff + 1'b1;
   assign nxt_bit   = idle ? '0 : (fall_edge ? bit_ff + 1'b1 : bit_ff);
   // Shift at the falling link clock so data settles before the next rise
   assign nxt_word  = load_word ? clean_word :
                      fall_edge ? {word_ff[WORD_MSB-1:0], 1'b0} : word_ff;
   assign nxt_last  = load_word ? clean_word : last_ff;
   assign nxt_sen   = in_frame;
   assign nxt_scl   = nxt_state == ST_HIGH;
   assign nxt_sda   = idle ? word_ff[WORD_MSB] :
                      fall_edge ? word_ff[WORD_MSB-1] : sda_ff;
   // Done sticks until read; a new completion beats the clear
   assign nxt_done  = frame_end || (done_ff && !rd_status);
   assign nxt_rdata = rd ? rd_mux : '0;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (send_req) nxt_state = ST_LEAD;
         ST_LEAD: if (tick) nxt_state = ST_HIGH;
         ST_HIGH: if (tick) nxt_state = ST_LOW;
         ST_LOW:  if (tick) nxt_state = last_bit ? ST_TAIL : ST_HIGH;
         ST_TAIL: if (tick) nxt_state = ST_GAP;
         ST_GAP:  if (tick) nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Control state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_ff <= '0;
      end else begin
         div_ff <= nxt_div;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bit_ff <= '0;
      end else begin
         bit_ff <= nxt_bit;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         word_ff <= '0;
      end else begin
         word_ff <= nxt_word;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last_ff <= '0;
      end else begin
         last_ff <= nxt_last;
      end
   end

   // Link pins straight from flops so the far end sees clean edges
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sen_ff <= 1'b0;
      end else begin
         sen_ff <= nxt_sen;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_ff <= 1'b0;
      end else begin
         scl_ff <= nxt_scl;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sda_ff <= 1'b0;
      end else begin
         sda_ff <= nxt_sda;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= nxt_done;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Outputs
   assign rdata                    = rdata_ff;
   assign link.serial_latch_enable = sen_ff;
   assign link.serial_clock        = scl_ff;
   assign link.serial_data         = sda_ff;
endmodule // tcap_serial_master
`default_nettype wire

// *** tcap_sync2.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module tcap_sync2 (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // Level
   input  wire logic din,
   output logic      dout
);
   logic meta_ff;
   logic sync_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
   assign dout = sync_ff;
endmodule // tcap_sync2
`default_nettype wire

// *** tunable_cap_serial_control_tb_top.sv ***
// Bench for master and capacitor ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module tunable_cap_serial_control_tb_top;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       standby_select;
   logic [4:0] capacitance_state_code;
   logic       word_applied;
   logic [7:0] seen;
   int         error_cnt = 0;
   int         checks_done = 0;
   int         applied = 0;
   int         base = 0;
   // Word written, then byte read back and applied
   logic [15:0] rows [6] = '{16'h0000, 16'h1f1f, 16'h2020, 16'h3f3f, 16'hc505, 16'h8a0a};
   tcap_link_if link_i ();
   tcap_serial_master tcap_serial_master_i (.clock(clock), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link_i));
   tunable_capacitor tunable_capacitor_i (.link(link_i), .clock(clock), .rst(rst),
      .standby_select(standby_select), .capacitance_state_code(capacitance_state_code),
      .word_applied(word_applied));
   tcap_link_properties tcap_link_properties_i (.clock(clock), .rst(rst),
      .serial_latch_enable(link_i.serial_latch_enable), .serial_clock(link_i.serial_clock),
      .serial_data(link_i.serial_data), .standby_select(standby_select),
      .capacitance_state_code(capacitance_state_code), .word_applied(word_applied));
   always #10 clock = ~clock;
   always @(negedge clock) if (word_applied === 1'b1) applied++;
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 seen = rdata;
   endtask
   // Polls done, then waits for the capacitor end to take the word
   task automatic send(input logic [7:0] w);
      base = applied;
      seen = 8'h00;
      wr_reg(4'h2, w);
      wr_reg(4'h0, 8'h01);
      for (int i = 0; i < 40 && seen[1] !== 1'b1; i++) rd_reg(4'h1);
      chk("done seen", seen & 8'h02, 8'h02);
      for (int i = 0; i < 20 && applied == base; i++) @(negedge clock);
      repeat (2) @(negedge clock);
   endtask
   initial begin
      #100000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd_reg(4'h1);
      chk("status after reset", seen, 8'h00);
      chk("state after reset", {2'b00, standby_select, capacitance_state_code}, 8'h00);
      $display("test reset done");
      foreach (rows[r]) begin
         send(rows[r][15:8]);
         rd_reg(4'h1);
         chk("done cleared", seen & 8'h02, 8'h00);
         rd_reg(4'h2);
         chk("word read back", seen, rows[r][7:0]);
         chk("state", {2'b00, standby_select, capacitance_state_code}, {2'b00, rows[r][5:0]});
         chk("apply count", 8'(applied - base), 8'h01);
         $display("test row %0d done", r);
      end
      // Second word and send land while the first frame runs
      base = applied;
      wr_reg(4'h2, 8'h15);
      wr_reg(4'h0, 8'h01);
      wr_reg(4'h2, 8'h2a);
      wr_reg(4'h0, 8'h01);
      rd_reg(4'h1);
      chk("busy flag", seen & 8'h01, 8'h01);
      repeat (120) @(negedge clock);
      rd_reg(4'h2);
      chk("word while busy", seen, 8'h15);
      chk("state while busy", {2'b00, standby_select, capacitance_state_code}, 8'h15);
      chk("busy apply count", 8'(applied - base), 8'h01);
      rd_reg(4'h7);
      chk("unmapped read", seen, 8'h00);
      $display("test busy done");
      // Reset in mid-run, then a full telegram must still land
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd_reg(4'h1);
      chk("status after rerun reset", seen, 8'h00);
      rd_reg(4'h2);
      chk("word after rerun reset", seen, 8'h00);
      chk("state after rerun reset", {2'b00, standby_select, capacitance_state_code}, 8'h00);
      send(8'h31);
      chk("state after rerun send", {2'b00, standby_select, capacitance_state_code}, 8'h31);
      chk("rerun apply count", 8'(applied - base), 8'h01);
      $display("test rerun reset done");
      wrap_up();
   end
endmodule // tunable_cap_serial_control_tb_top
`default_nettype wire

// *** tunable_capacitor.sv ***
// Tunable capacitor end: shift register and applied state
`timescale 1ns/1ps
`default_nettype none
`include "tcap_map.svh"
module tunable_capacitor (
   // Link
   tcap_link_if.device link,
   // Applied state, on the applying clock
   input  wire logic clock,
   input  wire logic rst,
   output logic                              standby_select,
   output logic [`TCAP_CODE_HI:`TCAP_CODE_LO] capacitance_state_code,
   output logic                              word_applied
);
   import tcap_pkg::*;
   tcap_word_t shift_ff;
   tcap_word_t nxt_shift;
   tcap_word_t word_ff;
   logic       en_sync;
   logic       en_prev_ff;
   logic       stby_ff;
   logic [`TCAP_CODE_HI:`TCAP_CODE_LO] code_ff;
   logic       applied_ff;
   wire        en_fall;

   // Shift on link clock while enabled; only last eight bits kept
   assign nxt_shift = {shift_ff[`TCAP_WORD_BITS-2:0], link.serial_data};
   always_ff @(posedge link.serial_clock or posedge rst) begin
      if (rst) begin
         shift_ff <= 8'h00;
      end else if (link.serial_latch_enable) begin
         shift_ff <= nxt_shift;
      end
   end

   // Capture at enable fall; link clock stops, so latch on the enable itself
   always_ff @(negedge link.serial_latch_enable or posedge rst) begin
      if (rst) begin
         word_ff <= 8'h00;
      end else begin
         word_ff <= shift_ff;
      end
   end

   // Word is stable once enable is low; hand over by synchronising the enable
   tcap_sync2 u_en_sync (
      .clock (clock),
      .rst   (rst),
      .din   (link.serial_latch_enable),
      .dout  (en_sync)
   );
   assign en_fall = en_prev_ff & ~en_sync;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         en_prev_ff <= 1'b0;
         stby_ff    <= 1'b0;
         code_ff    <= 5'h00;
         applied_ff <= 1'b0;
      end else begin
         en_prev_ff <= en_sync;
         applied_ff <= en_fall;
         if (en_fall) begin
            stby_ff <= word_ff[`TCAP_STBY_BIT];
            code_ff <= word_ff[`TCAP_CODE_HI:`TCAP_CODE_LO];
         end
      end
   end
   assign standby_select         = stby_ff;
   assign capacitance_state_code = code_ff;
   assign word_applied           = applied_ff;
endmodule // tunable_capacitor
`default_nettype wire
